//--- include/tprc_pkg.sv
// shared constants and types for the tuner power and reference control
package tprc_pkg;

   // register port geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int DIV_W  = 5;
   localparam int DIAG_W = 3;
   localparam int CTRL_W = 6;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_DIV    = 4'h1;
   localparam logic [ADDR_W-1:0] REG_TEST   = 4'h2;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h3;

   // values after power-on reset: prebias on, divide ratio one, everything else clear
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h10;
   localparam logic [DIV_W-1:0]  DIV_RST  = 5'h01;
   localparam logic [DIAG_W-1:0] DIAG_RST = 3'h0;

   // special codes
   localparam logic [DIV_W-1:0]  DIV_OFF      = 5'h00;
   localparam logic [DIAG_W-1:0] DIAG_LO_TEST = 3'h7;

   // pin synchroniser layout
   localparam int SYNC_STAGES = 3;
   localparam int PIN_COUNT   = 2;
   localparam int PIN_SHUTDOWN_PIN_N    = 0;
   localparam int PIN_REFSEL  = 1;
   localparam logic [PIN_COUNT-1:0] PIN_RST = 2'h0;

   // control register layout, msb first
   typedef struct packed {
      logic gainBoost;   // baseband_gain_boost
      logic prebiasEn;   // charge_pump_prebias_enable
      logic qDisable;    // q_channel_disable
      logic pwrDetEn;    // power_detector_enable
      logic standby;     // standby_bit
      logic powerDown;   // power_down_bit
   } tprc_ctrl_t;

   // operating modes
   typedef enum logic [1:0] {
      MODE_ACTIVE,
      MODE_STANDBY,
      MODE_POWERDOWN,
      MODE_SHUTDOWN
   } tprc_mode_t;

   // circuit enables driven to the analog sections
   typedef struct packed {
      logic sigPath;
      logic bus;
      logic xtalOsc;
      logic tcxoBuf;
      logic refOut;
      logic qChan;
      logic pwrDet;
      logic prebias;
      logic gainBoost;
      logic loTest;
   } tprc_enables_t;

endpackage : tprc_pkg

//--- rtl/tprc_ref_divider.sv
`timescale 1ns/1ps
// integer divider for the reference output: one-cycle tick every ratio cycles
module tprc_ref_divider
   import tprc_pkg::*;
#(
   parameter int W = DIV_W
) (
   // clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // control
   input  wire logic         enable,
   input  wire logic [W-1:0] ratio,
   // output
   output logic              tick
);

   logic [W-1:0] count;

   // count 0 .. ratio-1; the live ratio is compared, so a ratio change acts at once and a count at or past the new end wraps
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !enable) begin
         count <= '0;
      end else if (count >= ratio - W'(1)) begin
         count <= '0;
      end else begin
         count <= count + W'(1);
      end
   end

   // tick on the wrap, so the period is exactly ratio cycles
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= enable && (count >= ratio - W'(1));
      end
   end

endmodule : tprc_ref_divider

//--- rtl/tprc_top.sv
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module tprc_top
   import tprc_pkg::*;
(
   // clock and power-on reset
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   // pins from outside the clock domain
   input  wire logic                shutdown_pin_n,
   input  wire logic                ref_source_select_pin,
   // register port
   input  wire logic [ADDR_W-1:0]   regAddr,
   input  wire logic [DATA_W-1:0]   regWdata,
   input  wire logic                regWr,
   input  wire logic                regRd,
   output logic      [DATA_W-1:0]   regRdata,
   // circuit enables
   output tprc_enables_t            enables,
   output tprc_mode_t               mode,
   // divided reference
   output logic                     reference_output
);

   // register state
   tprc_ctrl_t              ctrl;
   logic [DIV_W-1:0]        refDivRatio;
   logic [DIAG_W-1:0]       diagSelect;

   // pin synchronisers and filtered levels
   logic [SYNC_STAGES-1:0]  pinSync [PIN_COUNT];
   logic [PIN_COUNT-1:0]    pinRaw;
   logic [PIN_COUNT-1:0]    pinLevel;

   // next values
   tprc_mode_t              next_mode;
   tprc_enables_t           next_enables;
   logic                    refCircuitsOn;
   logic                    refTick;
   logic                    busAlive;
   logic [DATA_W-1:0]       next_rdata;

   assign pinRaw[PIN_SHUTDOWN_PIN_N]   = shutdown_pin_n;
   assign pinRaw[PIN_REFSEL] = ref_source_select_pin;

   // three flops per pin; a change counts once stages two and three agree
   generate
      for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               pinSync[i] <= '0;
            end else begin
               pinSync[i] <= {pinSync[i][SYNC_STAGES-2:0], pinRaw[i]};
            end
         end

         // filtered level; a single-cycle glitch on the pin never lands here
         always_ff @(posedge ref_clk) begin
            if (!rst_n) begin
               pinLevel[i] <= PIN_RST[i];
            end else if (pinSync[i][1] == pinSync[i][2]) begin
               pinLevel[i] <= pinSync[i][2];
            end
         end
      end
   endgenerate

   // the bus is only alive when not in pin shutdown
   assign busAlive = enables.bus;

   // control register: reset only at power-on, held through every mode
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl <= tprc_ctrl_t'(CTRL_RST);
      end else if (regWr && busAlive && regAddr == REG_CTRL) begin
         ctrl <= tprc_ctrl_t'(regWdata[CTRL_W-1:0]);
      end
   end

   // divide ratio register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         refDivRatio <= DIV_RST;
      end else if (regWr && busAlive && regAddr == REG_DIV) begin
         refDivRatio <= regWdata[DIV_W-1:0];
      end
   end

   // diagnostic select register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         diagSelect <= DIAG_RST;
      end else if (regWr && busAlive && regAddr == REG_TEST) begin
         diagSelect <= regWdata[DIAG_W-1:0];
      end
   end

   // mode decode; a low pin with pwrDetEn clear comes first so it overrides both bits
   always_comb begin
      if (!pinLevel[PIN_SHUTDOWN_PIN_N] && !ctrl.pwrDetEn) begin
         next_mode = MODE_SHUTDOWN;
      end else if (ctrl.powerDown) begin
         next_mode = MODE_POWERDOWN;
      end else if (ctrl.standby) begin
         next_mode = MODE_STANDBY;
      end else begin
         next_mode = MODE_ACTIVE;
      end
   end

   // circuit enables from the next mode
   always_comb begin
      next_enables  = '0;
      refCircuitsOn = 1'b0;
      case (next_mode)
         MODE_ACTIVE: begin
            next_enables.sigPath = 1'b1;
            next_enables.bus     = 1'b1;
            refCircuitsOn        = 1'b1;
         end
         MODE_STANDBY: begin
            next_enables.bus = 1'b1;
            refCircuitsOn    = 1'b1;
         end
         MODE_POWERDOWN: begin
            next_enables.bus = 1'b1;
         end
         MODE_SHUTDOWN: begin
            next_enables.bus = 1'b0;
         end
         default: begin
            next_enables.bus = 1'b0;
         end
      endcase
      // reference source follows the strap level
      next_enables.xtalOsc = refCircuitsOn && !pinLevel[PIN_REFSEL];
      next_enables.tcxoBuf = refCircuitsOn && pinLevel[PIN_REFSEL];
      // a zero ratio shuts the output buffer rather than dividing
      next_enables.refOut  = refCircuitsOn && (refDivRatio != DIV_OFF);
      // configuration bits only matter while the signal path runs, except pwrDetEn, which also blocks pin shutdown
      next_enables.qChan     = next_enables.sigPath && !ctrl.qDisable;
      next_enables.pwrDet    = next_enables.sigPath && ctrl.pwrDetEn;
      next_enables.prebias   = next_enables.sigPath && ctrl.prebiasEn;
      next_enables.gainBoost = next_enables.sigPath && ctrl.gainBoost;
      next_enables.loTest    = next_enables.sigPath && (diagSelect == DIAG_LO_TEST);
   end

   // mode register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode <= MODE_SHUTDOWN;
      end else begin
         mode <= next_mode;
      end
   end

   // enable register; outputs come straight from here
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         enables <= '0;
      end else begin
         enables <= next_enables;
      end
   end

   // reference output divider
   tprc_ref_divider #(
      .W (DIV_W)
   ) u_ref_divider (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .enable  (enables.refOut),
      .ratio   (refDivRatio),
      .tick    (refTick)
   );

   // divided reference: a tick every ratio cycles; ratio one holds it high
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         reference_output <= 1'b0;
      end else begin
         reference_output <= refTick && enables.refOut;
      end
   end

   // read mux; unmapped offsets and a dead bus read as zero
   always_comb begin
      next_rdata = '0;
      if (regRd && busAlive) begin
         case (regAddr)
            REG_CTRL: begin
               next_rdata = DATA_W'(ctrl);
            end
            REG_DIV: begin
               next_rdata = DATA_W'(refDivRatio);
            end
            REG_TEST: begin
               next_rdata = DATA_W'(diagSelect);
            end
            REG_STATUS: begin
               next_rdata = {enables.loTest, pinLevel[PIN_REFSEL], enables.refOut,
                             enables.xtalOsc || enables.tcxoBuf, enables.sigPath,
                             pinLevel[PIN_SHUTDOWN_PIN_N], mode};
            end
            default: begin
               next_rdata = '0;
            end
         endcase
      end
   end

   // read data stand for exactly the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         regRdata <= '0;
      end else begin
         regRdata <= next_rdata;
      end
   end

endmodule : tprc_top

//--- testbench/tprc_chk_monitor.sv
`timescale 1ns/1ps
// watches the mode and enable outputs of the top
module tprc_chk
   import tprc_pkg::*;
(
   // clock and reset
   input wire logic              ref_clk,
   input wire logic              rst_n,
   // pins and read side
   input wire logic              shutdown_pin_n,
   input wire logic              ref_source_select_pin,
   input wire logic              regRd,
   input wire logic [DATA_W-1:0] regRdata,
   // outputs under watch
   input wire tprc_enables_t     enables,
   input wire tprc_mode_t        mode,
   input wire logic              reference_output
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // pins pass a filter, so only a long steady level is judged
   sequence pinHigh;
      shutdown_pin_n [*8];
   endsequence
   sequence selSteady;
      $stable(ref_source_select_pin) [*6];
   endsequence
   AST_SHUTDOWN_PIN_N_OFF: assert property (mode == MODE_SHUTDOWN |-> enables == 10'h000)
      else $error("shutdown with circuits on");
   AST_PIN_WAKE: assert property (pinHigh |-> mode != MODE_SHUTDOWN)
      else $error("shutdown with pin high");
   AST_PD_BUS: assert property (mode == MODE_POWERDOWN |-> enables.bus
      && !enables.sigPath && !(enables.xtalOsc | enables.tcxoBuf | enables.refOut))
      else $error("power-down enables wrong");
   AST_STANDBY_BIT_REF: assert property (mode == MODE_STANDBY |-> enables.bus
      && !enables.sigPath && (enables.xtalOsc | enables.tcxoBuf))
      else $error("standby enables wrong");
   AST_ACT_ALL: assert property (mode == MODE_ACTIVE |-> enables.sigPath
      && enables.bus && (enables.xtalOsc | enables.tcxoBuf))
      else $error("active enables wrong");
   AST_REF_SEL: assert property (selSteady ##0 (enables.xtalOsc | enables.tcxoBuf)
      |-> enables.tcxoBuf == ref_source_select_pin
      && enables.xtalOsc != ref_source_select_pin)
      else $error("reference source wrong");
   AST_REF_OFF: assert property ((!enables.refOut) [*2] |-> !reference_output)
      else $error("reference output while off");
   AST_GATED: assert property (!enables.sigPath |->
      !(enables.qChan | enables.pwrDet | enables.prebias | enables.gainBoost | enables.loTest))
      else $error("section on without signal path");
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdata == 8'h00)
      else $error("read data outside its cycle");
endmodule : tprc_chk

bind tprc_top tprc_chk tprc_chk_inst (
   .ref_clk(ref_clk), .rst_n(rst_n), .shutdown_pin_n(shutdown_pin_n),
   .ref_source_select_pin(ref_source_select_pin), .regRd(regRd), .regRdata(regRdata),
   .enables(enables), .mode(mode), .reference_output(reference_output));

//--- testbench/tprc_host.sv
`timescale 1ns/1ps
// host controller side of the register port
module tprc_host
   import tprc_pkg::*;
(
   // clock
   input  wire logic              ref_clk,
   // register port
   output logic      [ADDR_W-1:0] regAddr,
   output logic      [DATA_W-1:0] regWdata,
   output logic                   regWr,
   output logic                   regRd,
   input  wire logic [DATA_W-1:0] regRdata
);
   // idle bus at time zero
   initial begin
      regAddr = 4'h0;
      regWdata = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
   end
   // one-cycle write; data inverted after so stale values never pass
   // gain boost choice per modulation is left to the caller
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge ref_clk);
      regWr <= 1'b0;
      regWdata <= ~d;
   endtask : wr
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge ref_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask : rd
endmodule : tprc_host

//--- testbench/tprc_bench.sv
`timescale 1ns/1ps
// self-checking bench for power and reference control
module tprc_bench;
   import tprc_pkg::*;
   // row: control value, shutdown pin, expected mode
   typedef struct packed {
      logic [7:0] ctrl;
      logic       pin;
      tprc_mode_t mode;
   } tprc_row_t;
   logic              ref_clk, rst_n, shdnPin, refSel, regWr, regRd, reference_output;
   logic [ADDR_W-1:0] regAddr;
   logic [DATA_W-1:0] regWdata, regRdata, rdv;
   tprc_enables_t     enables;
   tprc_mode_t        mode;
   tprc_row_t         rows [8];
   logic [4:0]        dv [4];
   int                error_cnt, samples_checked, cyc, n;

   tprc_top tprc_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .shutdown_pin_n(shdnPin),
      .ref_source_select_pin(refSel), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .enables(enables),
      .mode(mode), .reference_output(reference_output));
   tprc_host tprc_host_inst (.ref_clk(ref_clk), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata));

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // hang guard, well above the expected run of about 730 cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      if (error_cnt == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test
   // pin filter plus enable register need about five edges
   task automatic settle();
      repeat (8) @(posedge ref_clk);
   endtask : settle
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rst_n <= 1'b1;
      settle();
   endtask : do_reset

   initial begin
      shdnPin = 1'b1;
      refSel = 1'b0;
      rows = '{'{8'h10, 1'b1, MODE_ACTIVE}, '{8'h00, 1'b1, MODE_ACTIVE},
               '{8'h2C, 1'b1, MODE_ACTIVE}, '{8'h11, 1'b1, MODE_POWERDOWN},
               '{8'h13, 1'b1, MODE_POWERDOWN}, '{8'h12, 1'b1, MODE_STANDBY},
               '{8'h13, 1'b0, MODE_SHUTDOWN}, '{8'h14, 1'b0, MODE_ACTIVE}};
      dv = '{5'h01, 5'h02, 5'h1F, 5'h00};
      do_reset();
      // mode table; each write lands in the mode the previous row's control value gives with the pin high
      foreach (rows[i]) begin
         shdnPin <= 1'b1;
         settle();
         tprc_host_inst.wr(REG_CTRL, rows[i].ctrl);
         shdnPin <= rows[i].pin;
         settle();
         chk(8'(mode), 8'(rows[i].mode));
         if (rows[i].mode == MODE_ACTIVE)
            chk(8'({enables.qChan, enables.pwrDet, enables.prebias, enables.gainBoost}),
                8'({~rows[i].ctrl[3], rows[i].ctrl[2], rows[i].ctrl[4], rows[i].ctrl[5]}));
         shdnPin <= 1'b1;
         settle();
         tprc_host_inst.rd(REG_CTRL, rdv);
         chk(rdv, rows[i].ctrl);
      end
      // pulse count over 62 cycles, which each nonzero ratio divides
      foreach (dv[i]) begin
         tprc_host_inst.wr(REG_DIV, 8'(dv[i]));
         repeat (40) @(posedge ref_clk);
         n = 0;
         repeat (62) begin
            @(posedge ref_clk);
            #1 n += reference_output;
         end
         chk(8'(n), (dv[i] == 5'h00) ? 8'h00 : 8'(62 / dv[i]));
      end
      for (int s = 0; s < 2; s++) begin
         refSel <= s[0];
         settle();
         chk(8'({enables.tcxoBuf, enables.xtalOsc}), 8'({s[0], ~s[0]}));
      end
      tprc_host_inst.wr(REG_TEST, 8'h07);
      repeat (3) @(posedge ref_clk);
      chk(8'(enables.loTest), 8'h01);
      tprc_host_inst.wr(REG_TEST, 8'h06);
      repeat (3) @(posedge ref_clk);
      chk(8'(enables.loTest), 8'h00);
      tprc_host_inst.rd(4'hF, rdv);
      chk(rdv, 8'h00);
      // status: active, pin high, tcxo selected, ratio zero, no lo test
      tprc_host_inst.rd(REG_STATUS, rdv);
      chk(rdv, 8'h5C);
      // pin shutdown kills the bus: writes dropped, reads give zero
      tprc_host_inst.wr(REG_CTRL, 8'h10);
      shdnPin <= 1'b0;
      settle();
      chk(8'(mode), 8'(MODE_SHUTDOWN));
      tprc_host_inst.wr(REG_DIV, 8'h05);
      tprc_host_inst.rd(REG_CTRL, rdv);
      chk(rdv, 8'h00);
      shdnPin <= 1'b1;
      settle();
      tprc_host_inst.rd(REG_DIV, rdv);
      chk(rdv, 8'h00);
      // second reset must bring back defaults
      do_reset();
      tprc_host_inst.rd(REG_CTRL, rdv);
      chk(rdv, 8'(CTRL_RST));
      tprc_host_inst.rd(REG_DIV, rdv);
      chk(rdv, 8'(DIV_RST));
      finish_test();
   end
endmodule : tprc_bench
